// File: core/drc_pkg.sv
package drc_pkg;

  // Clock and digital sampling period
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DIG_PERIOD_MS = 5;
  localparam int unsigned SAMPLE_CYC    = CLK_HZ / 1000 * DIG_PERIOD_MS;
  localparam int unsigned DIG_SPS       = 1000 / DIG_PERIOD_MS;

  // Recording limits, all times in ms
  localparam int unsigned REC_LIMIT   = 100;
  localparam int unsigned LEN_MIN_MS  = 100;
  localparam int unsigned LEN_MAX_MS  = 1_800_000;
  localparam int unsigned PRE_MIN_MS  = 200;
  localparam int unsigned PRE_MAX_MS  = 15_000;
  localparam int unsigned F_NOM_HZ    = 50;
  localparam int unsigned SPC_MAX     = 64;

  // Register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_TRIGSEL = 8'h08;
  localparam logic [7:0] A_MTRIG   = 8'h0c;
  localparam logic [7:0] A_CLRSEL  = 8'h10;
  localparam logic [7:0] A_CLRALL  = 8'h14;
  localparam logic [7:0] A_CLRNEW  = 8'h18;
  localparam logic [7:0] A_CLROLD  = 8'h1c;
  localparam logic [7:0] A_COUNT   = 8'h20;
  localparam logic [7:0] A_CAP     = 8'h24;
  localparam logic [7:0] A_MAXLEN  = 8'h28;
  localparam logic [7:0] A_MAXPRE  = 8'h2c;
  localparam logic [7:0] A_RECLEN  = 8'h30;
  localparam logic [7:0] A_PRETRIG = 8'h34;
  localparam logic [7:0] A_CHCFG   = 8'h38;
  localparam logic [7:0] A_RECIDX  = 8'h3c;
  localparam logic [7:0] A_RECID   = 8'h40;
  localparam logic [7:0] A_FREQ    = 8'h44;
  localparam logic [7:0] A_SAMPLE  = 8'h48;

  // Field positions
  localparam int unsigned CTRL_DIS_BIT  = 0;
  localparam int unsigned CTRL_MODE_BIT = 1;
  localparam int unsigned CH_ANA_LSB    = 0;
  localparam int unsigned CH_RATE_LSB   = 8;

  // Reset values
  localparam logic [20:0] RECLEN_RST = 21'h0003e8;
  localparam logic [13:0] PRE_RST    = 14'h00c8;
  localparam logic [4:0]  ANA_RST    = 5'h08;
  localparam logic [1:0]  RATE_RST   = 2'h0;

  // Command and status codes
  localparam logic [31:0] CMD_GO    = 32'h0000_0001;
  localparam logic [2:0]  SC_READY  = 3'h0;
  localparam logic [2:0]  SC_TRIG   = 3'h1;
  localparam logic [2:0]  SC_REC    = 3'h2;
  localparam logic [2:0]  SC_STORE  = 3'h3;
  localparam logic [2:0]  SC_FULL   = 3'h4;
  localparam logic [2:0]  SC_BADCFG = 3'h5;

  typedef enum logic [1:0] {FS_READY, FS_TRIG, FS_REC, FS_STORE} drc_fsm_e;

endpackage

// File: core/drc_core.sv
// Notes on behaviour
// RULE1: Enable field code 0 means enabled, 1 disabled; reset gives enabled.
// RULE2: Status reads 0 ready, 1 triggered, 2 recording, 3 storing, 4 full, 5 bad.
// RULE3: Never more than 100 recordings are held.
// RULE4: Capacity register shows recordings that fit, at most 100.
// RULE5: Count register tracks stored recordings on every store and clear.
// RULE6: Writing N to selective clear deletes the Nth recording, 1 the first.
// RULE7: Writing 1 to manual trigger starts a recording; register reads back 0.
// RULE8: Writing 1 to clear-all deletes every recording; reads back 0.
// RULE9: Writing 1 to clear-newest deletes only the latest recording.
// RULE10: Writing 1 to clear-oldest deletes only the earliest recording.
// RULE11: All binary channels are sampled once every 5 ms.
// RULE12: Recording starts on manual command or on an enabled trigger source.
// RULE13: Every binary channel can be chosen as a trigger source.
// RULE14: Trigger selection is one enable bit per channel, any of them triggers.
// RULE15: Longest single recording is reported in ms.
// RULE16: Largest allowed pre-trigger time is reported in ms.
// RULE17: Recording size follows channel counts, sample rate and length.
// RULE18: Channel 0 always reads 0, channel 1 always reads 1.
// RULE19: Phase-rotation channel reads 1 when sequence is reversed.
// RULE20: Display frequency reads 0 whenever frequency is not measurable.
// RULE21: Time-sync alarm channel is active while time sync is lost.
// RULE22: When full, mode 0 overwrites the oldest, mode 1 refuses new ones.
// RULE23: Full status shows when count meets capacity in refusing mode.
`timescale 1ns/100ps
module drc_core
  import drc_pkg::*;
#(
  parameter int unsigned NUM_IN     = 28,
  parameter int unsigned SMP_CYC    = SAMPLE_CYC,
  parameter int unsigned STORE_CYC  = 16,
  parameter logic [39:0] MEM_UNITS  = 40'h00ee6b2800
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NUM_IN-1:0] binaryIn,
  input  wire logic              phaseReversed,
  input  wire logic              timeSyncLost,
  input  wire logic              freqValid,
  input  wire logic [15:0]       freqIn
);

  localparam int unsigned NCH = NUM_IN + 4;
  localparam int unsigned IDW = 8;

  typedef logic [REC_LIMIT-1:0][IDW-1:0] drc_ids_t;

  typedef struct packed {
    logic [NUM_IN+1:0] inS1;
    logic [NUM_IN+1:0] inS2;
    logic [16:0]       fqS1;
    logic [16:0]       fqS2;
    logic              disCode;
    logic              modeKeep;
    logic [NCH-1:0]    trigSel;
    logic [20:0]       recLenMs;
    logic [13:0]       preMs;
    logic [4:0]        anaCnt;
    logic [1:0]        rateCode;
    logic [6:0]        recIdx;
    drc_fsm_e          st;
    logic [31:0]       tickCnt;
    logic [31:0]       postCnt;
    logic [31:0]       storeCnt;
    logic [6:0]        count;
    drc_ids_t          ids;
    logic [IDW-1:0]    seq;
    logic [NCH-1:0]    smp;
    logic [15:0]       dispFreq;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } drc_state_s;

  drc_state_s state_reg;
  drc_state_s state_next;

  logic [31:0] rate;
  logic [39:0] recSize;
  logic [39:0] capRaw;
  logic [6:0]  cap;
  logic [39:0] lenRaw;
  logic [31:0] maxLen;
  logic [31:0] maxPre;
  logic [31:0] postTicks;
  logic        cfgOk;
  logic [2:0]  statusCode;
  logic        tick;
  logic        autoTrig;
  logic        manTrig;
  logic        refuse;
  logic        commit;
  logic        wrEn;
  logic [NCH-1:0] chNow;

  function automatic drc_ids_t rmEntry(input drc_ids_t ids,
                                       input logic [6:0] k);
    drc_ids_t w;
    w = ids;
    for (int i = 0; i < REC_LIMIT - 1; i++) begin
      if (7'(i) >= k) begin
        w[i] = ids[i + 1];
      end
    end
    w[REC_LIMIT-1] = '0;
    return w;
  endfunction

  // Size of one recording in sample-ms units
  assign rate = 32'(state_reg.anaCnt) * (32'(SPC_MAX) >> state_reg.rateCode)
              * 32'(F_NOM_HZ) + 32'(NCH) * 32'(DIG_SPS); // RULE17
  assign recSize = 40'(rate) * 40'(state_reg.recLenMs); // RULE17
  assign capRaw = (recSize == '0) ? '0 : MEM_UNITS / recSize;
  assign cap = (capRaw > 40'(REC_LIMIT)) ? 7'(REC_LIMIT)
             : capRaw[6:0]; // RULE4
  assign lenRaw = (rate == '0) ? '0 : MEM_UNITS / 40'(rate);
  assign maxLen = (lenRaw > 40'(LEN_MAX_MS)) ? 32'(LEN_MAX_MS)
                : lenRaw[31:0]; // RULE15
  always_comb begin
    maxPre = 32'(PRE_MAX_MS);
    if (32'(state_reg.recLenMs) < maxPre) begin
      maxPre = 32'(state_reg.recLenMs);
    end
    if (maxLen < maxPre) begin
      maxPre = maxLen; // RULE16
    end
  end
  assign cfgOk = (capRaw != '0)
              && (32'(state_reg.recLenMs) >= 32'(LEN_MIN_MS))
              && (32'(state_reg.recLenMs) <= 32'(LEN_MAX_MS))
              && (32'(state_reg.preMs) >= 32'(PRE_MIN_MS))
              && (32'(state_reg.preMs) <= 32'(PRE_MAX_MS))
              && (21'(state_reg.preMs) < state_reg.recLenMs);
  assign postTicks = (32'(state_reg.recLenMs) - 32'(state_reg.preMs))
                   / 32'(DIG_PERIOD_MS);

  // Channel vector: constants, sync alarm, phase order, external inputs
  assign chNow = {state_reg.inS2[NUM_IN+1:2], state_reg.inS2[0],
                  state_reg.inS2[1], 1'h1, 1'h0}; // RULE18 RULE19 RULE21

  assign tick = (state_reg.tickCnt >= SMP_CYC - 1); // RULE11
  assign wrEn = psel & penable & pwrite & state_reg.pready;
  assign manTrig = wrEn && (paddr == A_MTRIG) && (pwdata == CMD_GO); // RULE7
  assign autoTrig = tick
                 && |(chNow & ~state_reg.smp & state_reg.trigSel); // RULE13 RULE14
  assign refuse = state_reg.modeKeep && (state_reg.count >= cap); // RULE22
  assign commit = (state_reg.st == FS_STORE)
               && (state_reg.storeCnt >= STORE_CYC - 1);

  always_comb begin
    statusCode = SC_READY;
    case (state_reg.st)
      FS_TRIG:  statusCode = SC_TRIG;
      FS_REC:   statusCode = SC_REC;
      FS_STORE: statusCode = SC_STORE;
      default: begin
        if (!cfgOk) begin
          statusCode = SC_BADCFG;
        end else if (refuse) begin
          statusCode = SC_FULL; // RULE23
        end
      end
    endcase
  end // RULE2

  always_comb begin
    drc_ids_t   wIds;
    logic [6:0] wCnt;
    logic [6:0] lim;
    wIds = state_reg.ids;
    wCnt = state_reg.count;
    lim = cap;
    state_next = state_reg;
    state_next.inS1 = {binaryIn, timeSyncLost, phaseReversed};
    state_next.inS2 = state_reg.inS1;
    state_next.fqS1 = {freqValid, freqIn};
    state_next.fqS2 = state_reg.fqS1;
    state_next.dispFreq = state_reg.fqS2[16] ? state_reg.fqS2[15:0]
                        : 16'h0000; // RULE20
    state_next.tickCnt = tick ? 32'h0 : state_reg.tickCnt + 32'h1;
    if (tick) begin
      state_next.smp = chNow; // RULE11
    end
    case (state_reg.st)
      FS_READY: begin
        if ((manTrig || autoTrig) && !state_reg.disCode && cfgOk
            && !refuse) begin
          state_next.st = FS_TRIG; // RULE1 RULE12 RULE22
        end
      end
      FS_TRIG: begin
        if (tick) begin
          state_next.st = FS_REC;
          state_next.postCnt = postTicks;
        end
      end
      FS_REC: begin
        if (tick) begin
          if (state_reg.postCnt <= 32'h1) begin
            state_next.st = FS_STORE;
            state_next.storeCnt = 32'h0;
          end else begin
            state_next.postCnt = state_reg.postCnt - 32'h1;
          end
        end
      end
      FS_STORE: begin
        state_next.storeCnt = state_reg.storeCnt + 32'h1;
        if (commit) begin
          state_next.st = FS_READY;
        end
      end
      default: state_next.st = FS_READY;
    endcase
    // Clear commands
    if (wrEn && paddr == A_CLRALL && pwdata == CMD_GO) begin
      wCnt = 7'h00; // RULE8
      wIds = '0;
    end else if (wrEn && paddr == A_CLRNEW && pwdata == CMD_GO
                 && wCnt != 7'h00) begin
      wCnt = wCnt - 7'h01; // RULE9
      wIds[wCnt] = '0;
    end else if (wrEn && paddr == A_CLROLD && pwdata == CMD_GO
                 && wCnt != 7'h00) begin
      wIds = rmEntry(wIds, 7'h00); // RULE10
      wCnt = wCnt - 7'h01;
    end else if (wrEn && paddr == A_CLRSEL && pwdata != 32'h0
                 && pwdata <= 32'(wCnt)) begin
      wIds = rmEntry(wIds, 7'(pwdata - 32'h1)); // RULE6
      wCnt = wCnt - 7'h01;
    end
    // Store of a finished recording
    if (commit) begin
      if (wCnt >= lim && !state_reg.modeKeep && wCnt != 7'h00) begin
        wIds = rmEntry(wIds, 7'h00); // RULE22
        wCnt = wCnt - 7'h01;
      end
      if (wCnt < lim) begin
        wIds[wCnt] = state_reg.seq; // RULE3
        wCnt = wCnt + 7'h01;
        state_next.seq = state_reg.seq + 8'h01;
      end
    end
    state_next.ids = wIds;
    state_next.count = wCnt; // RULE5
    // Setting writes
    if (wrEn) begin
      case (paddr)
        A_CTRL: begin
          state_next.disCode = pwdata[CTRL_DIS_BIT]; // RULE1
          state_next.modeKeep = pwdata[CTRL_MODE_BIT];
        end
        A_TRIGSEL: state_next.trigSel = pwdata[NCH-1:0]; // RULE14
        A_RECLEN:  state_next.recLenMs = pwdata[20:0];
        A_PRETRIG: state_next.preMs = pwdata[13:0];
        A_CHCFG: begin
          state_next.anaCnt = pwdata[CH_ANA_LSB +: 5];
          state_next.rateCode = pwdata[CH_RATE_LSB +: 2];
        end
        A_RECIDX:  state_next.recIdx = pwdata[6:0];
        default: ;
      endcase
    end
    // APB answer, one wait-free access phase after setup
    state_next.pready = psel && !penable;
    state_next.pslverr = 1'h0;
    state_next.prdata = 32'h0;
    if (psel && !penable) begin
      case (paddr)
        A_CTRL: state_next.prdata = 32'({state_reg.modeKeep,
                                          state_reg.disCode});
        A_STATUS:  state_next.prdata = 32'(statusCode); // RULE2
        A_TRIGSEL: state_next.prdata = 32'(state_reg.trigSel);
        A_MTRIG, A_CLRSEL, A_CLRALL, A_CLRNEW, A_CLROLD:
          state_next.prdata = 32'h0; // RULE7 RULE8
        A_COUNT:   state_next.prdata = 32'(state_reg.count); // RULE5
        A_CAP:     state_next.prdata = 32'(cap); // RULE4
        A_MAXLEN:  state_next.prdata = maxLen; // RULE15
        A_MAXPRE:  state_next.prdata = maxPre; // RULE16
        A_RECLEN:  state_next.prdata = 32'(state_reg.recLenMs);
        A_PRETRIG: state_next.prdata = 32'(state_reg.preMs);
        A_CHCFG: state_next.prdata = 32'({state_reg.rateCode, 3'h0,
                                           state_reg.anaCnt});
        A_RECIDX:  state_next.prdata = 32'(state_reg.recIdx);
        A_RECID: begin
          if (state_reg.recIdx < state_reg.count) begin
            state_next.prdata = 32'(state_reg.ids[state_reg.recIdx]);
          end
        end
        A_FREQ:    state_next.prdata = 32'(state_reg.dispFreq); // RULE20
        A_SAMPLE:  state_next.prdata = 32'(state_reg.smp);
        default:   state_next.pslverr = 1'h1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.disCode <= 1'h0; // RULE1
      state_reg.recLenMs <= RECLEN_RST;
      state_reg.preMs <= PRE_RST;
      state_reg.anaCnt <= ANA_RST;
      state_reg.rateCode <= RATE_RST;
      state_reg.st <= FS_READY;
      state_reg.smp <= NCH'(2); // RULE18
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_count_limit: assert property (state_reg.count <= 7'(REC_LIMIT)) // RULE3
    else $error("stored count above limit");
  chk_count_cap: assert property (cap <= 7'(REC_LIMIT)) // RULE4
    else $error("capacity above limit");
  chk_status_full: assert property ( // RULE23
    psel && !penable && paddr == A_STATUS && state_reg.st == FS_READY
    && cfgOk && refuse |=> prdata == 32'(SC_FULL))
    else $error("full status missing");
  chk_clear_all: assert property ( // RULE8
    wrEn && paddr == A_CLRALL && pwdata == CMD_GO && !commit
    |=> state_reg.count == 7'h00)
    else $error("clear all left recordings");
  chk_clear_new: assert property ( // RULE9
    wrEn && paddr == A_CLRNEW && pwdata == CMD_GO && !commit
    && state_reg.count != 7'h00
    |=> state_reg.count == $past(state_reg.count) - 7'h01)
    else $error("clear newest wrong count");
  chk_oldest_shift: assert property ( // RULE10
    wrEn && paddr == A_CLROLD && pwdata == CMD_GO && !commit
    && state_reg.count > 7'h01
    |=> state_reg.ids[0] == $past(state_reg.ids[1]))
    else $error("clear oldest wrong entry");
  chk_sample_hold: assert property ( // RULE11
    !tick |=> $stable(state_reg.smp))
    else $error("sample changed between ticks");
  chk_const_chan: assert property ( // RULE18
    state_reg.smp[0] == 1'h0 && state_reg.smp[1] == 1'h1)
    else $error("constant channel wrong");
  chk_freq_zero: assert property ( // RULE20
    !state_reg.fqS2[16] |=> state_reg.dispFreq == 16'h0000)
    else $error("display frequency not zero");
  chk_start_gate: assert property ( // RULE1
    state_reg.st == FS_READY ##1 state_reg.st == FS_TRIG
    |-> $past(state_reg.disCode) == 1'h0 && $past(refuse) == 1'h0)
    else $error("start while disabled or refused");
  chk_man_start: assert property ( // RULE7
    state_reg.st == FS_READY && manTrig && !state_reg.disCode && cfgOk
    && !refuse |=> state_reg.st == FS_TRIG)
    else $error("manual trigger ignored");
  chk_store_count: assert property ( // RULE5
    commit && !wrEn && state_reg.count < cap
    |=> state_reg.count == $past(state_reg.count) + 7'h01)
    else $error("store did not count");

  cov_auto_trig: cover property (state_reg.st == FS_READY && autoTrig);
  cov_store:     cover property (commit);
  cov_full_fifo: cover property (commit && state_reg.count >= cap);
  cov_sel_clear: cover property (wrEn && paddr == A_CLRSEL);

endmodule // drc_core

// File: dv/drc_tb.sv
`timescale 1ns/100ps
module testbench
  import drc_pkg::*;
;
  localparam longint      MEM_U   = 28_800_000;
  localparam longint      RATE    = 8 * 64 * 50 + 32 * 200;
  localparam logic [31:0] CAP_EXP = 32'(MEM_U / (RATE * 300));
  localparam longint      RATE_R1 = 8 * 32 * 50 + 32 * 200;

  logic        sys_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [27:0] binaryIn;
  logic        phaseReversed;
  logic        timeSyncLost;
  logic        freqValid;
  logic [15:0] freqIn;
  int          errCount;
  int          nCompared;
  logic [31:0] rdVal;
  logic        rdErr;
  logic [31:0] id0;
  logic [31:0] id1;
  logic [31:0] id2;
  logic [31:0] idx;

  drc_core #(
    .NUM_IN   (28),
    .SMP_CYC  (20),
    .STORE_CYC(4),
    .MEM_UNITS(40'(MEM_U))
  ) u_dut (
    .sys_clk      (sys_clk),
    .arst_n       (arst_n),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .binaryIn     (binaryIn),
    .phaseReversed(phaseReversed),
    .timeSyncLost (timeSyncLost),
    .freqValid    (freqValid),
    .freqIn       (freqIn)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (errCount == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      errCount++;
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string name);
    apb(1'b0, a, 32'h0);
    check(name, exp, rdVal);
  endtask

  task automatic rd_id(input logic [6:0] i, output logic [31:0] id);
    wr(A_RECIDX, {25'h0, i});
    apb(1'b0, A_RECID, 32'h0);
    id = rdVal;
  endtask

  // Waits for the recorder to go busy, then back to idle
  task automatic wait_rec();
    int   n;
    logic busy;
    n = 0;
    do begin
      apb(1'b0, A_STATUS, 32'h0);
      busy = rdVal[2:0] inside {SC_TRIG, SC_REC, SC_STORE};
      n++;
    end while (!busy && n < 50);
    check("busy", 32'h1, {31'h0, busy});
    do begin
      apb(1'b0, A_STATUS, 32'h0);
      busy = rdVal[2:0] inside {SC_TRIG, SC_REC, SC_STORE};
      n++;
    end while (busy && n < 700);
    check("idle", 32'h0, {31'h0, busy});
  endtask

  task automatic rec_manual();
    wr(A_MTRIG, CMD_GO);
    wait_rec();
  endtask

  task automatic t_reset();
    rdc(A_CTRL, 32'h0, "ctrl");
    rdc(A_COUNT, 32'h0, "count");
    rdc(A_STATUS, {29'h0, SC_BADCFG}, "status");
    apb(1'b0, 8'hfc, 32'h0);
    check("slverr", 32'h1, {31'h0, rdErr});
    check("unmapped", 32'h0, rdVal);
    wr(A_RECLEN, 32'd300);
    rdc(A_MAXLEN, 32'(MEM_U / RATE), "maxlen");
    rdc(A_MAXPRE, 32'd300, "maxpre");
    rdc(A_CAP, CAP_EXP, "cap");
    wr(A_CHCFG, 32'h0000_0108);
    rdc(A_CAP, 32'(MEM_U / (RATE_R1 * 300)), "cap rate");
    wr(A_CHCFG, 32'h0000_0008);
    rdc(A_STATUS, {29'h0, SC_READY}, "status");
  endtask

  task automatic t_sample();
    binaryIn <= 28'h5a5a5a5;
    phaseReversed <= 1'b1;
    timeSyncLost <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rdc(A_SAMPLE, {28'h5a5a5a5, 4'he}, "sample");
    phaseReversed <= 1'b0;
    timeSyncLost <= 1'b0;
    binaryIn <= 28'h0;
    repeat (60) @(posedge sys_clk);
    rdc(A_SAMPLE, {28'h0, 4'h2}, "sample");
    phaseReversed <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rdc(A_SAMPLE, {28'h0, 4'ha}, "phase only");
    phaseReversed <= 1'b0;
    freqIn <= 16'h1388;
    freqValid <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdc(A_FREQ, 32'h1388, "freq");
    freqValid <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rdc(A_FREQ, 32'h0, "freq");
  endtask

  task automatic t_trig();
    rec_manual();
    rdc(A_MTRIG, 32'h0, "mtrig");
    rdc(A_COUNT, 32'h1, "count");
    wr(A_TRIGSEL, 32'h0000_00a0);
    binaryIn <= 28'h8;
    wait_rec();
    rdc(A_COUNT, 32'h2, "count");
    binaryIn <= 28'h0;
    wr(A_TRIGSEL, 32'h0);
    wr(A_CTRL, 32'h1);
    wr(A_MTRIG, CMD_GO);
    repeat (600) @(posedge sys_clk);
    rdc(A_COUNT, 32'h2, "disabled count");
  endtask

  task automatic t_full();
    wr(A_CTRL, 32'h2);
    rec_manual();
    rdc(A_COUNT, 32'h3, "count");
    rdc(A_STATUS, {29'h0, SC_FULL}, "status");
    wr(A_MTRIG, CMD_GO);
    repeat (600) @(posedge sys_clk);
    rdc(A_COUNT, 32'h3, "refused count");
    rd_id(7'd0, id0);
    rd_id(7'd1, id1);
    rd_id(7'd2, id2);
    wr(A_CTRL, 32'h0);
    rec_manual();
    rdc(A_COUNT, 32'h3, "fifo count");
    rd_id(7'd0, idx);
    check("fifo oldest", id1, idx);
    rd_id(7'd1, idx);
    check("fifo second", id2, idx);
  endtask

  task automatic t_clear();
    rd_id(7'd0, id0);
    rd_id(7'd2, id2);
    wr(A_CLRALL, 32'h2);
    rdc(A_COUNT, 32'h3, "bad code count");
    wr(A_CLRSEL, 32'h2);
    rdc(A_COUNT, 32'h2, "clrsel count");
    rd_id(7'd1, idx);
    check("clrsel second", id2, idx);
    wr(A_CLRNEW, CMD_GO);
    rdc(A_COUNT, 32'h1, "clrnew count");
    rd_id(7'd0, idx);
    check("clrnew oldest", id0, idx);
    rec_manual();
    rd_id(7'd1, id1);
    wr(A_CLROLD, CMD_GO);
    rdc(A_COUNT, 32'h1, "clrold count");
    rd_id(7'd0, idx);
    check("clrold left", id1, idx);
    wr(A_CLRALL, CMD_GO);
    rdc(A_COUNT, 32'h0, "clrall count");
    rdc(A_CLRALL, 32'h0, "clrall");
  endtask

  initial begin
    #1_000_000;
    errCount++;
    $display("[FAIL] watchdog expected finish seen timeout");
    complete_run();
  end

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    binaryIn = 28'h0;
    phaseReversed = 1'b0;
    timeSyncLost = 1'b0;
    freqValid = 1'b0;
    freqIn = 16'h0;
    errCount = 0;
    nCompared = 0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_sample();
    t_trig();
    t_full();
    t_clear();
    complete_run();
  end
endmodule // testbench
